// ==== hdl/mii_port_defines.vh ====
// Purpose: Constants for the external PHY media-independent port.
// Assumes: Core clock clk_sys at 100 MHz, link clocks sampled as plain inputs.
// Notes:   Strap codes, widths and counts used by the port and its buffer.
`ifndef MII_PORT_DEFINES_VH
`define MII_PORT_DEFINES_VH
`define MODE_W          4
`define MODE_INTERNAL   4'h0
`define MODE_EXT_XTAL   4'h1
`define MODE_EXT_OSC    4'h2
`define NIB_W           4
`define NIB_MSB         3
`define BUF_W           5
`define BUF_DEPTH       2
`define BUF_FULL        2'h2
`define BUF_CNT_W       2
`define SYNC_W          2
`define NIB_ZERO        4'h0
`endif

// ==== hdl/nibble_buffer.v ====
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, both sides on clk_sys.
// Notes:   Ready on the fill side falls only when both entries are held.
`timescale 1ns/10ps
`include "mii_port_defines.vh"
module nibble_buffer (
  clk_sys,
  rstn,
  flush,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  input  wire                clk_sys;
  input  wire                rstn;
  input  wire                flush;
  input  wire                in_valid;
  output wire                in_ready;
  input  wire [`BUF_W-1:0]   in_data;
  output wire                out_valid;
  input  wire                out_ready;
  output wire [`BUF_W-1:0]   out_data;

  reg  [`BUF_W-1:0]     mem_q [0:`BUF_DEPTH-1];
  reg                   wr_ptr_q;
  reg                   rd_ptr_q;
  reg  [`BUF_CNT_W-1:0] cnt_q;
  wire                  push;
  wire                  pop;

  // Honest full and empty from the count
  assign in_ready  = (cnt_q != `BUF_FULL);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage and pointers
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'd0;
      mem_q[0] <= {`BUF_W{1'b0}};
      mem_q[1] <= {`BUF_W{1'b0}};
    end else if (flush) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'd0;
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data;
        wr_ptr_q        <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'd1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'd1;
      end
    end
  end
endmodule

// ==== hdl/mii_external_phy_port.v ====
// Purpose: Media-independent port to an external PHY, run from clk_sys.
// Assumes: Link clocks well below clk_sys/4, sampled through two flops.
// Notes:   Transmit words arrive one nibble per transmit clock; a frame
//          ends when the source marks its last nibble. Receive nibbles
//          pass a two-entry buffer; a full buffer drops and flags overrun.
`timescale 1ns/10ps
`include "mii_port_defines.vh"
module mii_external_phy_port (
  clk_sys,
  rstn,
  phy_mode,
  use_internal_phy,
  tx_valid,
  tx_ready,
  tx_data,
  tx_last,
  phy_tx_clock,
  phy_tx_enable,
  phy_tx_data,
  network_op_clock,
  phy_carrier_sense,
  phy_collision,
  phy_rx_clock,
  phy_rx_valid,
  phy_rx_data,
  duplex_select_n,
  carrier_present,
  collision_seen,
  full_duplex,
  rx_valid,
  rx_ready,
  rx_data,
  rx_last,
  rx_overrun
);
  input  wire               clk_sys;
  input  wire               rstn;
  input  wire [`MODE_W-1:0] phy_mode;
  output reg                use_internal_phy;
  input  wire               tx_valid;
  output reg                tx_ready;
  input  wire [`NIB_W-1:0]  tx_data;
  input  wire               tx_last;
  input  wire               phy_tx_clock;
  output reg                phy_tx_enable;
  output reg  [`NIB_W-1:0]  phy_tx_data;
  output reg                network_op_clock;
  input  wire               phy_carrier_sense;
  input  wire               phy_collision;
  input  wire               phy_rx_clock;
  input  wire               phy_rx_valid;
  input  wire [`NIB_W-1:0]  phy_rx_data;
  input  wire               duplex_select_n;
  output reg                carrier_present;
  output reg                collision_seen;
  output reg                full_duplex;
  output reg                rx_valid;
  input  wire               rx_ready;
  output reg  [`NIB_W-1:0]  rx_data;
  output reg                rx_last;
  output reg                rx_overrun;

  // Transmit states
  localparam TX_IDLE = 2'b00;
  localparam TX_SEND = 2'b01;
  localparam TX_STOP = 2'b10;

  reg  [`SYNC_W-1:0] txc_s_q;
  reg  [`SYNC_W-1:0] rxc_s_q;
  reg  [`SYNC_W-1:0] crs_s_q;
  reg  [`SYNC_W-1:0] col_s_q;
  reg  [`SYNC_W-1:0] fdx_s_q;
  reg  [`SYNC_W-1:0] rxdv_s_q;
  reg  [`MODE_W-1:0] mode_s1_q;
  reg  [`MODE_W-1:0] mode_s2_q;
  reg  [`NIB_W-1:0]  rxd_s1_q;
  reg  [`NIB_W-1:0]  rxd_s2_q;
  reg                txc_prev_q;
  reg                rxc_prev_q;
  reg                ext_en_q;
  reg  [1:0]         tx_st_q;
  reg                rx_dv_prev_q;
  reg                rx_hold_q;
  reg  [`NIB_W-1:0]  rx_hold_d_q;
  wire               txc_rise;
  wire               txc_fall;
  wire               rxc_rise;
  wire               ext_sel;
  wire               buf_in_ready;
  wire               buf_out_valid;
  wire [`BUF_W-1:0]  buf_out_data;
  wire               buf_pop;
  wire               rx_take;
  wire               rx_end;
  wire               buf_push;
  wire [`BUF_W-1:0]  buf_in_data;

  // Strap decode: external codes only enable the MII
  assign ext_sel = (mode_s2_q == `MODE_EXT_XTAL) || (mode_s2_q == `MODE_EXT_OSC);

  // Mode followed every cycle from the synchronised strap
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ext_en_q         <= 1'b0;
      use_internal_phy <= 1'b1;
    end else begin
      ext_en_q         <= ext_sel;
      use_internal_phy <= ~ext_sel;
    end
  end

  // Two-flop synchronisers for every pin input
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txc_s_q  <= {`SYNC_W{1'b0}};
      rxc_s_q  <= {`SYNC_W{1'b0}};
      crs_s_q  <= {`SYNC_W{1'b0}};
      col_s_q  <= {`SYNC_W{1'b0}};
      fdx_s_q  <= {`SYNC_W{1'b1}};
      rxdv_s_q <= {`SYNC_W{1'b0}};
      rxd_s1_q <= `NIB_ZERO;
      rxd_s2_q <= `NIB_ZERO;
      mode_s1_q <= `MODE_INTERNAL;
      mode_s2_q <= `MODE_INTERNAL;
    end else begin
      mode_s1_q <= phy_mode; // Strap is a pin too
      mode_s2_q <= mode_s1_q;
      txc_s_q  <= {txc_s_q[0], phy_tx_clock};
      rxc_s_q  <= {rxc_s_q[0], phy_rx_clock};
      crs_s_q  <= {crs_s_q[0], phy_carrier_sense};
      col_s_q  <= {col_s_q[0], phy_collision};
      fdx_s_q  <= {fdx_s_q[0], duplex_select_n};
      rxdv_s_q <= {rxdv_s_q[0], phy_rx_valid};
      rxd_s1_q <= phy_rx_data;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // Edge detection on the synchronised clocks
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txc_prev_q <= 1'b0;
      rxc_prev_q <= 1'b0;
    end else begin
      txc_prev_q <= txc_s_q[1];
      rxc_prev_q <= rxc_s_q[1];
    end
  end
  assign txc_rise = txc_s_q[1] & ~txc_prev_q;
  assign txc_fall = ~txc_s_q[1] & txc_prev_q;
  assign rxc_rise = rxc_s_q[1] & ~rxc_prev_q;

  // Status: duplex, carrier, gated collision, network tick
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      full_duplex      <= 1'b0;
      carrier_present  <= 1'b0;
      collision_seen   <= 1'b0;
      network_op_clock <= 1'b0;
    end else begin
      full_duplex      <= ext_en_q & ~fdx_s_q[1];
      carrier_present  <= ext_en_q & crs_s_q[1];
      collision_seen   <= ext_en_q & fdx_s_q[1] & col_s_q[1];
      network_op_clock <= ext_en_q & txc_s_q[1];
    end
  end

  // Transmit: launch on falling edge, PHY samples on the rising edge
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_st_q       <= TX_IDLE;
      tx_ready      <= 1'b0;
      phy_tx_enable <= 1'b0;
      phy_tx_data   <= `NIB_ZERO;
    end else begin
      tx_ready <= 1'b0;
      if (!ext_en_q) begin
        tx_st_q       <= TX_IDLE;
        phy_tx_enable <= 1'b0;
        phy_tx_data   <= `NIB_ZERO;
      end else if (txc_fall) begin
        case (tx_st_q)
          TX_IDLE: begin
            if (tx_valid) begin
              phy_tx_enable <= 1'b1;
              phy_tx_data   <= tx_data;
              tx_ready      <= 1'b1;
              tx_st_q       <= tx_last ? TX_STOP : TX_SEND;
            end
          end
          TX_SEND: begin
            if (tx_valid) begin
              phy_tx_data <= tx_data;
              tx_ready    <= 1'b1;
              if (tx_last) begin
                tx_st_q <= TX_STOP;
              end
            end else begin
              phy_tx_enable <= 1'b0;
              phy_tx_data   <= `NIB_ZERO;
              tx_st_q       <= TX_IDLE;
            end
          end
          TX_STOP: begin
            phy_tx_enable <= 1'b0;
            phy_tx_data   <= `NIB_ZERO;
            tx_st_q       <= TX_IDLE;
          end
          default: begin
            tx_st_q <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // Receive: nibble held one step so the last one carries the end mark
  assign rx_take     = ext_en_q & rxc_rise & rxdv_s_q[1];
  assign rx_end      = ext_en_q & rxc_rise & ~rxdv_s_q[1] & rx_dv_prev_q;
  assign buf_push    = rx_hold_q & (rx_take | rx_end);
  assign buf_in_data = {rx_end, rx_hold_d_q};

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_dv_prev_q <= 1'b0;
      rx_hold_q    <= 1'b0;
      rx_hold_d_q  <= `NIB_ZERO;
      rx_overrun   <= 1'b0;
    end else begin
      if (rxc_rise) begin
        rx_dv_prev_q <= rxdv_s_q[1] & ext_en_q;
      end
      if (rx_take) begin
        rx_hold_q   <= 1'b1;
        rx_hold_d_q <= rxd_s2_q;
      end else if (rx_end || !ext_en_q) begin
        rx_hold_q <= 1'b0;
      end
      if (buf_push && !buf_in_ready) begin
        rx_overrun <= 1'b1;
      end else if (rx_take && !rx_dv_prev_q) begin
        rx_overrun <= 1'b0;
      end
    end
  end

  // Crossing buffer into the core side
  nibble_buffer u_rx_buf (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .flush     (~ext_en_q),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  // Registered output stage, refilled when empty or taken
  assign buf_pop = buf_out_valid & (~rx_valid | rx_ready);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
      rx_data  <= `NIB_ZERO;
      rx_last  <= 1'b0;
    end else if (buf_pop) begin
      rx_valid <= 1'b1;
      rx_data  <= buf_out_data[`NIB_MSB:0];
      rx_last  <= buf_out_data[`NIB_W];
    end else if (rx_ready) begin
      rx_valid <= 1'b0;
    end
  end
endmodule

// ==== tb/mii_port_monitor.sv ====
// Purpose: Concurrent checks on the external PHY port pins.
// Assumes: Link clocks near 125 ns, clk_sys 10 ns.
// Notes:   Status checks allow six cycles for the synchronisers.
`timescale 1ns/10ps
module mii_port_monitor (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic [3:0] phy_mode,
  input wire logic       use_internal_phy,
  input wire logic       tx_ready,
  input wire logic [3:0] tx_data,
  input wire logic       phy_tx_enable,
  input wire logic [3:0] phy_tx_data,
  input wire logic       network_op_clock,
  input wire logic       phy_collision,
  input wire logic       duplex_select_n,
  input wire logic       collision_seen,
  input wire logic       full_duplex,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [3:0] rx_data,
  input wire logic       rx_last
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Settled status inputs
  sequence s_col_half;
    (phy_collision && duplex_select_n && !use_internal_phy)[*6];
  endsequence
  sequence s_full;
    (!duplex_select_n && !use_internal_phy)[*6];
  endsequence
  property p_mode_sel;
    $past(rstn) && $past(rstn, 2) && $past(rstn, 3) |->
      use_internal_phy == !($past(phy_mode, 3) == 4'h1 || $past(phy_mode, 3) == 4'h2);
  endproperty
  property p_int_quiet;
    use_internal_phy && $past(use_internal_phy) |->
      !phy_tx_enable && phy_tx_data == 4'h0 && !network_op_clock;
  endproperty
  property p_tx_launch;
    tx_ready |-> phy_tx_enable && phy_tx_data == $past(tx_data);
  endproperty
  property p_tx_hold;
    !tx_ready && !$fell(phy_tx_enable) |-> $stable(phy_tx_data);
  endproperty
  property p_tx_gap;
    tx_ready |=> (!tx_ready)[*8];
  endproperty
  property p_fdx;
    s_full |-> full_duplex;
  endproperty
  property p_hdx;
    duplex_select_n[*6] |-> !full_duplex;
  endproperty
  property p_col_ign;
    (!duplex_select_n)[*6] |-> !collision_seen;
  endproperty
  property p_col_half;
    s_col_half |-> collision_seen;
  endproperty
  property p_rx_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data) && $stable(rx_last);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode select wrong");
  a_int_quiet: assert property (p_int_quiet) else $error("pins not quiet");
  a_tx_launch: assert property (p_tx_launch) else $error("tx nibble wrong");
  a_tx_hold: assert property (p_tx_hold) else $error("tx nibble moved");
  a_tx_gap: assert property (p_tx_gap) else $error("tx nibbles too close");
  a_fdx: assert property (p_fdx) else $error("full duplex missed");
  a_hdx: assert property (p_hdx) else $error("half duplex missed");
  a_col_ign: assert property (p_col_ign) else $error("collision in full duplex");
  a_col_half: assert property (p_col_half) else $error("collision missed");
  a_rx_hold: assert property (p_rx_hold) else $error("rx word moved");
endmodule
bind mii_external_phy_port mii_port_monitor mon_u (
  .clk_sys(clk_sys), .rstn(rstn), .phy_mode(phy_mode), .use_internal_phy(use_internal_phy),
  .tx_ready(tx_ready), .tx_data(tx_data), .phy_tx_enable(phy_tx_enable),
  .phy_tx_data(phy_tx_data), .network_op_clock(network_op_clock),
  .phy_collision(phy_collision), .duplex_select_n(duplex_select_n),
  .collision_seen(collision_seen), .full_duplex(full_duplex), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last));

// ==== tb/phy_model.sv ====
// Purpose: Behavioural external PHY: link clocks and receive frames.
// Assumes: Both link clocks 125 ns, free running, unrelated phase.
// Notes:   Receive data shows the inverted last nibble between frames, 4'h5 before the first.
`timescale 1ns/10ps
module phy_model (
  output logic       tx_clk,
  output logic       rx_clk,
  output logic       rx_dv,
  output logic [3:0] rxd
);
  // Free-running link clocks
  initial begin
    tx_clk = 0;
    forever #62.5 tx_clk = ~tx_clk;
  end
  initial begin
    rx_clk = 0;
    rx_dv = 0;
    rxd = 4'h5;
    #21;
    forever #62.5 rx_clk = ~rx_clk;
  end
  // One frame, nibble 0 in low bits, moved on falling edges
  task send(input int n, input logic [63:0] w);
    int i;
    for (i = 0; i < n; i++) begin
      @(negedge rx_clk);
      rx_dv <= 1'b1;
      rxd <= w[4*i +: 4];
    end
    @(negedge rx_clk);
    rx_dv <= 1'b0;
    rxd <= ~rxd;
  endtask
endmodule

// ==== tb/mii_external_phy_port_tb.sv ====
// Purpose: Self-checking bench for the external PHY port.
// Assumes: PHY model makes both link clocks.
// Notes:   Expected nibbles kept in queues from the xorshift source.
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module mii_external_phy_port_tb;
  logic        clk_sys = 0, rstn = 0, tx_valid = 0, tx_last = 0, rx_ready = 0;
  logic        duplex_select_n = 0, phy_carrier_sense = 0, phy_collision = 0, rx_hold = 1;
  logic [3:0]  phy_mode = 4'h0, tx_data = 4'h0;
  wire         use_internal_phy, tx_ready, phy_tx_clock, phy_tx_enable, network_op_clock;
  wire         carrier_present, collision_seen, full_duplex, phy_rx_clock, phy_rx_valid;
  wire         rx_valid, rx_last, rx_overrun;
  wire  [3:0]  phy_tx_data, phy_rx_data, rx_data;
  logic [4:0]  exp_q[$], got_q[$];
  bit   [31:0] seed = 32'h0000_170B;
  int          failures = 0, n_tests = 0, i, net_ticks = 0;
  mii_external_phy_port dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .phy_mode(phy_mode), .use_internal_phy(use_internal_phy),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
    .phy_tx_clock(phy_tx_clock), .phy_tx_enable(phy_tx_enable), .phy_tx_data(phy_tx_data),
    .network_op_clock(network_op_clock), .phy_carrier_sense(phy_carrier_sense),
    .phy_collision(phy_collision), .phy_rx_clock(phy_rx_clock), .phy_rx_valid(phy_rx_valid),
    .phy_rx_data(phy_rx_data), .duplex_select_n(duplex_select_n),
    .carrier_present(carrier_present), .collision_seen(collision_seen),
    .full_duplex(full_duplex), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_last(rx_last), .rx_overrun(rx_overrun));
  // Network tick rises counted for the rate check
  always @(posedge network_op_clock) net_ticks++;
  phy_model phy_u (.tx_clk(phy_tx_clock), .rx_clk(phy_rx_clock), .rx_dv(phy_rx_valid),
                   .rxd(phy_rx_data));
  always #5 clk_sys = ~clk_sys;
  // Core side stalls at random unless held off
  always @(posedge clk_sys) begin
    #1 rx_ready = !rx_hold && (rnd() & 1);
  end
  // Nibbles seen on the wire and at the core
  always @(posedge phy_tx_clock) if (phy_tx_enable === 1'b1) got_q.push_back({1'b0, phy_tx_data});
  always @(posedge clk_sys) if (rx_valid === 1'b1 && rx_ready === 1'b1) got_q.push_back({rx_last, rx_data});
  function bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task print_verdict();
    $display("counts: %0d checks, %0d mismatches", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wait_cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Waits for n words, then compares them in order
  task check_q(input string name, input int n);
    int k;
    for (k = 0; got_q.size() < n && k < 2000; k++) @(posedge clk_sys);
    #1;
    if (k >= 2000) begin
      failures++;
      print_verdict();
    end else begin
      `CHK(name, n, got_q.size())
      for (k = 0; k < n; k++) `CHK(name, exp_q[k], got_q[k])
      exp_q.delete();
      got_q.delete();
      $display("test %s done", name);
    end
  endtask
  // Cut frame leaves the end mark off and stops feeding
  task tx_frame(input int n, input bit cut);
    int i, k;
    for (i = 0; i < n; i++) begin
      tx_valid = 1;
      tx_data = 4'(rnd());
      tx_last = !cut && (i == n - 1);
      exp_q.push_back({1'b0, tx_data});
      for (k = 0; tx_ready !== 1'b1 && k < 100; k++) @(posedge clk_sys);
      if (k >= 100) begin
        failures++;
        print_verdict();
      end
      @(posedge clk_sys);
      #1;
    end
    tx_valid = 0;
    tx_last = 0;
  endtask
  task rx_frame(input int n, input bit keep);
    logic [63:0] w;
    int i;
    w = {rnd(), rnd()};
    if (keep) for (i = 0; i < n; i++) exp_q.push_back({i == n - 1, w[4*i +: 4]});
    phy_u.send(n, w);
  endtask
  // Main sequence
  initial begin
    wait_cycles(2);
    rstn = 1;
    for (i = 0; i < 16; i++) begin
      phy_mode = 4'(i);
      wait_cycles(4);
      `CHK("internal", (i != 1 && i != 2), use_internal_phy)
      if (i != 1 && i != 2) `CHK("quiet", 0, {phy_tx_enable, phy_tx_data, network_op_clock})
    end
    $display("test mode done");
    phy_mode = 4'h1;
    phy_collision = 1;
    phy_carrier_sense = 1;
    for (i = 0; i < 2; i++) begin
      duplex_select_n = i[0];
      wait_cycles(8);
      `CHK("duplex", !i[0], full_duplex)
      `CHK("collision", i[0], collision_seen)
      `CHK("carrier", 1'b1, carrier_present)
    end
    net_ticks = 0;
    wait_cycles(250);
    `CHK("net_tick", 20, net_ticks)
    phy_collision = 0;
    phy_carrier_sense = 0;
    $display("test status done");
    phy_mode = 4'h2;
    wait_cycles(4);
    `CHK("carrier_idle", 1'b0, carrier_present)
    got_q.delete();
    tx_frame(5, 0);
    wait_cycles(16);
    tx_frame(1, 0);
    wait_cycles(16);
    tx_frame(3, 1);
    wait_cycles(30);
    check_q("tx", 9);
    rx_hold = 0;
    rx_frame(6, 1);
    check_q("rx", 6);
    rx_hold = 1;
    rx_frame(9, 0);
    wait_cycles(30);
    `CHK("overrun", 1'b1, rx_overrun)
    $display("test overrun done");
    rx_hold = 0;
    wait_cycles(80);
    got_q.delete();
    rx_frame(4, 1);
    check_q("rx_after", 4);
    `CHK("overrun_clear", 1'b0, rx_overrun)
    print_verdict();
  end
endmodule
